/* verilog/drc_ctrl.sv */
// Purpose: Drives row/column strobes, write select, address and data.
// Assumes: q is sampled synchronously; pins meet the device directly.
// Notes: Requests are taken only while req_ready is high.

`timescale 1ns/1ps
`default_nettype none

module drc_ctrl #(
  parameter int PAUSE_CYC = drc_pkg::C_PAUSE,
  parameter int REF_CYC = drc_pkg::C_REF,
  parameter int INIT_N = drc_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic col_first_en,
  input wire logic hidden_en,
  input wire logic req_valid,
  input wire drc_pkg::drc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_data,
  output drc_pkg::drc_pins_t pins,
  input wire logic q,
  output logic init_done
);
  import drc_pkg::*;

  if (PAUSE_CYC < 1 || PAUSE_CYC > 65535 || INIT_N < 8 || INIT_N > 255)
  begin : g_chk
    $error("PAUSE_CYC or INIT_N out of range");
  end

  typedef enum logic [3:0] {
    ST_PAUSE, ST_IDLE, ST_ROW, ST_RCD, ST_COL, ST_ACC, ST_RMW, ST_WRH,
    ST_HPRE, ST_RLEAD, ST_RLOW, ST_RGAP, ST_PRE
  } drc_state_t;

  drc_state_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] left_q, left_d;
  drc_pins_t pins_q, pins_d;
  drc_req_t req_q, req_d;
  logic ready_q, ready_d;
  logic rsp_v_q, rsp_v_d;
  logic rsp_dat_q, rsp_dat_d;
  logic init_q, init_d;
  logic ref_done;
  logic ref_due;
  logic [ROW_W-1:0] ref_row;

  wire cnt_zero = (cnt_q == 16'h0000);
  wire [15:0] cnt_dec = cnt_zero ? 16'h0000 : cnt_q - 16'h0001;
  wire take = ready_q && req_valid;
  wire is_write = (req_q.op == DRC_OP_WRITE);
  wire [ADDR_W-1:0] row_addr = req_q.addr[2*ADDR_W-1:ADDR_W];
  wire [ADDR_W-1:0] col_addr = req_q.addr[ADDR_W-1:0];
  wire [ADDR_W-1:0] ref_addr = {1'b0, ref_row};
  wire do_hidden = (req_q.op == DRC_OP_READ) && hidden_en && ref_due;

  drc_ref_tick #(
    .INTERVAL(REF_CYC)
  ) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .run(init_q),
    .done(ref_done),
    .due(ref_due),
    .row(ref_row)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_dec;
    left_d = left_q;
    pins_d = pins_q;
    req_d = req_q;
    ready_d = 1'b0;
    rsp_v_d = 1'b0;
    rsp_dat_d = rsp_dat_q;
    init_d = init_q;
    ref_done = 1'b0;
    unique case (st_q)
      ST_PAUSE: begin
        pins_d = PINS_IDLE;
        if (cnt_zero) begin
          left_d = 8'(INIT_N);
          st_d = ST_RLEAD;
        end
      end
      ST_IDLE: begin
        if (take) begin
          req_d = req;
          pins_d.addr = req.addr[2*ADDR_W-1:ADDR_W];
          pins_d.we_b = 1'b1;
          st_d = ST_ROW;
        end else if (ref_due) begin
          left_d = 8'h01;
          st_d = ST_RLEAD;
        end else begin
          ready_d = 1'b1;
        end
      end
      ST_ROW: begin
        pins_d.ras_b = 1'b0;
        cnt_d = 16'(C_RCD - 1);
        st_d = ST_RCD;
      end
      ST_RCD: begin
        if (cnt_zero) begin
          pins_d.addr = col_addr;
          if (is_write) begin
            pins_d.we_b = 1'b0;
            pins_d.d = req_q.wdata;
          end
          st_d = ST_COL;
        end
      end
      ST_COL: begin
        pins_d.cas_b = 1'b0;
        cnt_d = is_write ? 16'(C_WP - 1) : 16'(C_ACC - 1);
        st_d = ST_ACC;
      end
      ST_ACC: begin
        if (cnt_zero) begin
          if (!is_write) begin
            rsp_v_d = 1'b1;
            rsp_dat_d = q;
          end
          if (req_q.op == DRC_OP_RMW) begin
            pins_d.d = req_q.wdata;
            cnt_d = 16'(C_DS - 1);
            st_d = ST_RMW;
          end else if (do_hidden) begin
            pins_d.ras_b = 1'b1;
            cnt_d = 16'(C_RP - 1);
            st_d = ST_HPRE;
          end else begin
            pins_d = PINS_IDLE;
            pins_d.addr = pins_q.addr;
            cnt_d = 16'(C_RP - 1);
            st_d = ST_PRE;
          end
        end
      end
      ST_RMW: begin
        if (cnt_zero) begin
          pins_d.we_b = 1'b0;
          cnt_d = 16'(C_WP - 1);
          st_d = ST_WRH;
        end
      end
      ST_WRH: begin
        if (cnt_zero) begin
          pins_d = PINS_IDLE;
          pins_d.addr = pins_q.addr;
          cnt_d = 16'(C_RP - 1);
          st_d = ST_PRE;
        end
      end
      ST_HPRE: begin
        if (cnt_zero) begin
          pins_d.ras_b = 1'b0;
          left_d = 8'h01;
          cnt_d = 16'(C_RAS - 1);
          st_d = ST_RLOW;
        end
      end
      ST_RLEAD: begin
        pins_d.we_b = 1'b1;
        if (col_first_en) begin
          pins_d.cas_b = 1'b0;
        end else begin
          pins_d.addr = ref_addr;
        end
        st_d = ST_RGAP;
        cnt_d = 16'h0000;
      end
      ST_RGAP: begin
        // Row address settles during the gap, ahead of the strobe
        if (!col_first_en) begin
          pins_d.addr = ref_addr;
        end
        if (cnt_zero) begin
          pins_d.ras_b = 1'b0;
          cnt_d = 16'(C_RAS - 1);
          st_d = ST_RLOW;
        end
      end
      ST_RLOW: begin
        if (cnt_zero) begin
          pins_d.ras_b = 1'b1;
          ref_done = 1'b1;
          cnt_d = 16'(C_RP - 1);
          if (left_q > 8'h01) begin
            left_d = left_q - 8'h01;
            st_d = ST_RGAP;
          end else begin
            pins_d.cas_b = 1'b1;
            st_d = ST_PRE;
          end
        end
      end
      ST_PRE: begin
        if (cnt_zero) begin
          init_d = 1'b1;
          ready_d = !ref_due;
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_PAUSE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_PAUSE;
      cnt_q <= 16'(PAUSE_CYC - 1);
      left_q <= 8'h00;
      pins_q <= PINS_IDLE;
      req_q <= '0;
      ready_q <= 1'b0;
      rsp_v_q <= 1'b0;
      rsp_dat_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      left_q <= left_d;
      pins_q <= pins_d;
      req_q <= req_d;
      ready_q <= ready_d;
      rsp_v_q <= rsp_v_d;
      rsp_dat_q <= rsp_dat_d;
      init_q <= init_d;
    end
  end

  assign pins = pins_q;
  assign req_ready = ready_q;
  assign rsp_valid = rsp_v_q;
  assign rsp_data = rsp_dat_q;
  assign init_done = init_q;

endmodule : drc_ctrl

`default_nettype wire

/* verilog/drc_pkg.sv */
// Purpose: Shared constants and types of the memory strobe controller.
// Assumes: 200 MHz clock; a one-bit-wide multiplexed-address memory.
// Notes: Times are kept as printed; cycle counts derive from them.

package drc_pkg;

  localparam int CLK_NS = 5;
  localparam int ADDR_W = 10;
  localparam int ROW_W = 9;

  // Device access times
  localparam int T_CAC_NS = 15;
  localparam int T_RAC_NS = 60;
  // Controller margins
  localparam int T_RCD_NS = 20;
  localparam int T_RAS_NS = 60;
  localparam int T_RP_NS = 40;
  localparam int T_WP_NS = 15;
  localparam int T_DS_NS = 5;
  localparam int T_PAUSE_US = 200;
  localparam int T_RET_MS = 8;
  localparam int REF_ROWS = 512;
  localparam int INIT_CYCLES = 8;

  // Least times round up
  localparam int C_CAC = (T_CAC_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RAC = (T_RAC_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RCD = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RAS = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_WP = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_DS = (T_DS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_PAUSE = (T_PAUSE_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Refresh spacing is a longest time: rounds down
  localparam int C_REF = (T_RET_MS * 1000000 / CLK_NS) / REF_ROWS;
  // Column-to-sample wait, one spare cycle for the input flop
  localparam int C_ACC_RAW = (C_RAC - C_RCD - 1 > C_CAC) ?
                             (C_RAC - C_RCD - 1) : C_CAC;
  localparam int C_ACC = C_ACC_RAW + 1;

  typedef enum logic [1:0] {
    DRC_OP_READ,
    DRC_OP_WRITE,
    DRC_OP_RMW
  } drc_op_t;

  typedef struct packed {
    drc_op_t op;
    logic [2*ADDR_W-1:0] addr;
    logic wdata;
  } drc_req_t;

  typedef struct packed {
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [ADDR_W-1:0] addr;
    logic d;
  } drc_pins_t;

  localparam drc_pins_t PINS_IDLE = '{ras_b: 1'b1, cas_b: 1'b1,
                                      we_b: 1'b1, addr: 10'h000,
                                      d: 1'b0};

endpackage : drc_pkg

/* verilog/drc_ref_tick.sv */
// Purpose: Refresh pacing and the host-kept row counter.
// Assumes: done pulses once per finished refresh row.
// Notes: A tick landing with done still raises due.

`timescale 1ns/1ps
`default_nettype none

module drc_ref_tick #(
  parameter int INTERVAL = drc_pkg::C_REF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic done,
  output logic due,
  output logic [drc_pkg::ROW_W-1:0] row
);
  import drc_pkg::*;

  if (INTERVAL < 2 || INTERVAL > 65535) begin : g_chk
    $error("INTERVAL out of range");
  end

  logic [15:0] tmr_q;
  logic due_q;
  logic [ROW_W-1:0] row_q;

  wire tick = run && (tmr_q == 16'h0000);
  wire [15:0] tmr_d = tick ? 16'(INTERVAL - 1) : tmr_q - 16'h0001;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_q <= 16'h0000;
      due_q <= 1'b0;
      row_q <= 9'h000;
    end else begin
      if (run) begin
        tmr_q <= tmr_d;
      end
      due_q <= tick | (due_q & ~done);
      if (done) begin
        row_q <= row_q + 9'h001;
      end
    end
  end

  assign due = due_q;
  assign row = row_q;

endmodule : drc_ref_tick

`default_nettype wire

/* tb/drc_mem.sv */
// Purpose: Behavioural one-bit dynamic memory on the controller pins.
// Assumes: Strobes change only at the controller's clock edges.
// Notes: rows counts every row strobe fall.
`timescale 1ns/1ps
`default_nettype none
module drc_mem (
  input wire drc_pkg::drc_pins_t pins,
  output logic q
);
  import drc_pkg::*;
  bit mem_q [bit [19:0]];
  logic [9:0] row_q = 10'h000;
  logic [9:0] col_q = 10'h000;
  logic val = 1'b0;
  logic on = 1'b0;
  realtime ras_t = 0;
  int rows = 0;
  int hid = 0;
  //////////////////////////////////////////////////////////////////////////
  // Released output shows the inverse of its last value
  assign q = on ? val : ~val;
  always @(negedge pins.ras_b) begin
    rows++;
    if (on) hid++;
    ras_t = $realtime;
    if (pins.cas_b) row_q = pins.addr;
  end
  always @(negedge pins.cas_b) begin
    if (!pins.ras_b) begin
      col_q = pins.addr;
      if (!pins.we_b) mem_q[{row_q, col_q}] = pins.d;
      else begin
        #(T_CAC_NS);
        if ($realtime < ras_t + T_RAC_NS) #(ras_t + T_RAC_NS - $realtime);
        val = mem_q[{row_q, col_q}];
        on = !pins.cas_b;
      end
    end
  end
  always @(negedge pins.we_b)
    if (!pins.cas_b && !pins.ras_b) mem_q[{row_q, col_q}] = pins.d;
  always @(posedge pins.cas_b) on = 1'b0;
endmodule : drc_mem
`default_nettype wire

/* tb/drc_ctrl_chk.sv */
// Purpose: Pin order and timing checks on the strobe controller.
// Assumes: One clock, reset rst_b.
// Notes: Bound to drc_ctrl below.
`timescale 1ns/1ps
`default_nettype none
module drc_chk #(
  parameter int PAUSE_CYC = 40000,
  parameter int REF_CYC = 3125
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire drc_pkg::drc_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_data,
  input wire drc_pkg::drc_pins_t pins,
  input wire logic q,
  input wire logic init_done
);
  import drc_pkg::*;
  logic [15:0] cyc_q;
  logic [15:0] gap_q;
  drc_op_t op_q;
  logic [9:0] col_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q <= 16'h0000;
      gap_q <= 16'h0000;
    end else begin
      cyc_q <= cyc_q + {15'h0000, ~&cyc_q};
      gap_q <= pins.ras_b ? gap_q + 16'h0001 : 16'h0000;
    end
  end
  always_ff @(posedge clk) begin
    if (req_valid && req_ready) begin
      op_q <= req.op;
      col_q <= req.addr[9:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  chk_row_addr: assert property (
    $fell(pins.ras_b) && pins.cas_b |-> $stable(pins.addr))
    else $error("row address moved at row strobe");
  chk_col_addr: assert property (
    $fell(pins.cas_b) && !pins.ras_b |-> $stable(pins.addr) &&
    pins.addr == col_q && pins.we_b == (op_q != DRC_OP_WRITE))
    else $error("column address or write select wrong");
  chk_early_data: assert property (
    $fell(pins.cas_b) && !pins.ras_b && !pins.we_b |->
    $stable(pins.d) && !$past(pins.we_b))
    else $error("early write data not set up");
  chk_late_data: assert property (
    $fell(pins.we_b) && !pins.cas_b |-> $stable(pins.d))
    else $error("delayed write data not set up");
  chk_read_data: assert property (
    rsp_valid |-> rsp_data == $past(q) && !$past(pins.cas_b, 4) &&
    !$past(pins.ras_b, 12))
    else $error("read sampled too early or wrongly");
  chk_col_first: assert property (
    $fell(pins.ras_b) && !pins.cas_b |-> !$past(pins.cas_b) ##1 !pins.cas_b)
    else $error("column-first refresh order broken");
  chk_pause_wait: assert property (
    $fell(pins.ras_b) |-> cyc_q >= 16'(PAUSE_CYC))
    else $error("row strobe before power-up pause");
  chk_init_hold: assert property (
    init_done |=> init_done)
    else $error("init flag dropped");
  chk_ready_init: assert property (
    req_ready |-> init_done)
    else $error("request offered before init");
  chk_refresh_gap: assert property (
    init_done |-> gap_q < 16'(REF_CYC + 64))
    else $error("refresh interval exceeded");
endmodule : drc_chk
bind drc_ctrl drc_chk #(.PAUSE_CYC(PAUSE_CYC), .REF_CYC(REF_CYC)) u_chk (
  .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .pins(pins), .q(q), .init_done(init_done));
`default_nettype wire

/* tb/test_drc_ctrl.sv */
// Purpose: Self-checking bench for the strobe controller.
// Assumes: Shortened pause and refresh spacing.
// Notes: Memory model sits on the pins.
`timescale 1ns/1ps
`default_nettype none
module test_drc_ctrl;
  import drc_pkg::*;
  localparam int REFC = 200;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic col_first_en = 1'b1;
  logic hidden_en = 1'b0;
  logic req_valid = 1'b0;
  drc_req_t req = '0;
  logic req_ready, rsp_valid, rsp_data, q, init_done;
  drc_pins_t pins;
  int error_cnt = 0;
  int checks = 0;
  logic [19:0] at [4] = '{20'h00000, 20'hfffff, 20'h003ff, 20'hffc00};
  always #2.5 clk = ~clk;
  drc_ctrl #(.PAUSE_CYC(20), .REF_CYC(REFC)) uut (
    .clk(clk), .rst_b(rst_b), .col_first_en(col_first_en),
    .hidden_en(hidden_en), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .pins(pins), .q(q), .init_done(init_done));
  drc_mem mem (.pins(pins), .q(q));
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk
  task automatic acc(input drc_op_t op, input logic [19:0] a,
                     input logic w, input logic exp);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(req_ready, 1'b1, "request not offered");
    req = '{op: op, addr: a, wdata: w};
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    chk(req_ready, 1'b0, "ready held after take");
    if (op != DRC_OP_WRITE) begin
      n = 0;
      while (rsp_valid !== 1'b1 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(rsp_valid, 1'b1, "no read response");
      chk(rsp_data, exp, "read data");
      @(posedge clk);
      #1;
      chk(rsp_valid, 1'b0, "response longer than a cycle");
    end
  endtask : acc
  //////////////////////////////////////////////////////////////////////////
  task automatic t_init;
    int n;
    int r0;
    n = 0;
    r0 = mem.rows;
    while (init_done !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(init_done, 1'b1, "init never finished");
    checks++;
    if (mem.rows - r0 != INIT_CYCLES) begin
      error_cnt++;
      $display("MISMATCH t=%0t init cycles %0d", $time, mem.rows);
    end
    $display("test init done");
  endtask : t_init
  task automatic t_data;
    for (int i = 0; i < 4; i++) acc(DRC_OP_WRITE, at[i], 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) acc(DRC_OP_READ, at[i], 1'b0, 1'b1);
    acc(DRC_OP_WRITE, at[0], 1'b0, 1'b0);
    acc(DRC_OP_READ, at[0], 1'b1, 1'b0);
    acc(DRC_OP_READ, at[1], 1'b0, 1'b1);
    $display("test data done");
  endtask : t_data
  task automatic t_rmw;
    acc(DRC_OP_RMW, at[2], 1'b0, 1'b1);
    acc(DRC_OP_READ, at[2], 1'b1, 1'b0);
    $display("test rmw done");
  endtask : t_rmw
  task automatic t_reset;
    // Mid-run reset; init then runs as row-only refresh
    col_first_en = 1'b0;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(pins === PINS_IDLE, 1'b1, "pins not idle in reset");
    chk(req_ready | rsp_valid | init_done, 1'b0, "outputs set in reset");
    rst_b = 1'b1;
    t_init();
    $display("test reset done");
  endtask : t_reset
  task automatic t_refresh;
    int r0;
    int h0;
    for (int m = 0; m < 2; m++) begin
      col_first_en = m[0];
      r0 = mem.rows;
      repeat (2 * REFC + 60) @(posedge clk);
      #1;
      checks++;
      if (mem.rows - r0 < 2) begin
        error_cnt++;
        $display("MISMATCH t=%0t too few refreshes", $time);
      end
      acc(DRC_OP_READ, at[1], 1'b0, 1'b1);
    end
    hidden_en = 1'b1;
    h0 = mem.hid;
    for (int i = 0; i < 32; i++) acc(DRC_OP_READ, at[i % 4], 1'b0, i[0]);
    checks++;
    if (mem.hid == h0) begin
      error_cnt++;
      $display("MISMATCH t=%0t no hidden refresh", $time);
    end
    $display("test refresh done");
  endtask : t_refresh
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_init();
    t_data();
    t_rmw();
    t_reset();
    t_refresh();
    conclude();
  end
  initial begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end
endmodule : test_drc_ctrl
`default_nettype wire
